// File: src/timer_defines.svh
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH
// Register byte addresses on the special function bus
`define TCTRL_ADDR 8'h88
`define TMODE_ADDR 8'h89
`define T0LOW_ADDR 8'h8a
`define T1LOW_ADDR 8'h8b
`define T0HIGH_ADDR 8'h8c
`define T1HIGH_ADDR 8'h8d
// Bit-address page of the control register (0x88 to 0x8f)
`define TCTRL_BIT_PAGE 5'h11
// Control register fields
`define OVF1_BIT 7
`define RUN1_BIT 6
`define OVF0_BIT 5
`define RUN0_BIT 4
`define XFLAG1_BIT 3
`define XTYPE1_BIT 2
`define XFLAG0_BIT 1
`define XTYPE0_BIT 0
// Mode register fields
`define GATE_ONE_BIT 7
`define CSEL1_BIT 6
`define MODE1_HI 5
`define MODE1_LO 4
`define GATE_ZERO_BIT 3
`define CSEL0_BIT 2
`define MODE0_HI 1
`define MODE0_LO 0
// Reset values and counting constants
`define BYTE_RESET 8'h00
`define BYTE_ONES 8'hff
`define COUNT_ONE 8'h01
`endif

// File: src/timer_pkg.sv
package timer_pkg;
   // Two-bit mode field of each timer
   typedef enum logic [1:0] {
      mode_13bit = 2'b00,
      mode_16bit = 2'b01,
      mode_reload = 2'b10,
      mode_split = 2'b11
   } timer_mode_type;
endpackage

// File: src/pin_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sampler (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Asynchronous pin
   input wire logic pin,
   // Synchronised level and edges
   output logic level,
   output logic fall,
   output logic rise
);
   logic meta_reg, meta_next;
   logic sync_reg, sync_next;
   logic prev_reg, prev_next;

   ////////////////////////////////////////////////////////////////////////
   // First stage feeds only the second stage
   always_comb begin
      meta_next = pin;
      sync_next = meta_reg;
      prev_next = sync_reg;
   end

   // Idle pins sit high, so reset to one avoids a false falling edge
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
         prev_reg <= 1'b1;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
         prev_reg <= prev_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Edges from two consecutive synchronised samples
   assign level = sync_reg;
   assign fall = prev_reg & ~sync_reg;
   assign rise = ~prev_reg & sync_reg;
endmodule
`default_nettype wire

// File: src/dual_timer.sv
`include "timer_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module dual_timer
   import timer_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Special function register bus
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   // Bit-addressed writes
   input wire logic [7:0] sfr_bit_addr,
   input wire logic sfr_bit_value,
   input wire logic sfr_bit_wr,
   // Timebase ticks from the prescaler
   input wire logic timer0_tick,
   input wire logic timer1_tick,
   // External pins
   input wire logic count_pin_zero,
   input wire logic count_pin_one,
   input wire logic ext_gate_zero_input,
   input wire logic ext_gate_one_input,
   input wire logic ext_zero_polarity,
   input wire logic ext_one_polarity,
   // Interrupt controller
   input wire logic timer0_irq_enable,
   input wire logic timer1_irq_enable,
   input wire logic vector_timer0,
   input wire logic vector_timer1,
   input wire logic vector_ext_zero,
   input wire logic vector_ext_one,
   output logic timer0_irq,
   output logic timer1_irq,
   // Overflow event for other peripherals
   output logic timer1_overflow
);
   logic [7:0] timer_control_reg, timer_control_next;
   logic [7:0] timer_mode_register_reg, timer_mode_register_next;
   logic [7:0] timer0_low_byte_reg, timer0_low_byte_next;
   logic [7:0] timer0_high_byte_reg, timer0_high_byte_next;
   logic [7:0] timer1_low_byte_reg, timer1_low_byte_next;
   logic [7:0] timer1_high_byte_reg, timer1_high_byte_next;
   logic [7:0] rdata_reg, rdata_next;
   logic irq0_reg, irq0_next, irq1_reg, irq1_next, ovf1_reg, ovf1_next;
   logic c0_fall, c1_fall;
   logic g0_level, g0_fall, g0_rise, g1_level, g1_fall, g1_rise;
   timer_mode_type mode0, mode1;
   logic split, inc0, inc0_high, inc1, ovf0, ovf0_high, ovf1_evt;
   logic timer0_gate_bit_ok, timer1_gate_bit_ok, act0, act1, edge0, edge1;
   logic [16:0] step0, step1;
   logic [8:0] step0_high;
   logic wr_ctrl, wr_low0, wr_high0, wr_low1, wr_high1, wr_mode, bit_hit;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   pin_sampler count0_sampler (.clk(clk), .sys_rst(sys_rst), .pin(count_pin_zero),
      .level(), .fall(c0_fall), .rise());
   pin_sampler count1_sampler (.clk(clk), .sys_rst(sys_rst), .pin(count_pin_one),
      .level(), .fall(c1_fall), .rise());
   pin_sampler timer0_gate_bit_sampler (.clk(clk), .sys_rst(sys_rst), .pin(ext_gate_zero_input),
      .level(g0_level), .fall(g0_fall), .rise(g0_rise));
   pin_sampler timer1_gate_bit_sampler (.clk(clk), .sys_rst(sys_rst), .pin(ext_gate_one_input),
      .level(g1_level), .fall(g1_fall), .rise(g1_rise));

   ////////////////////////////////////////////////////////////////////////
   // One increment step; returns {overflow, high, low}
   function automatic logic [16:0] count_step(input timer_mode_type m,
                                              input logic [7:0] lo,
                                              input logic [7:0] hi);
      logic [13:0] c13;
      logic [16:0] c16;
      logic [8:0] c8;
      logic [16:0] res;
      c13 = {1'b0, hi, lo[4:0]} + 14'h1;
      c16 = {1'b0, hi, lo} + 17'h1;
      c8 = {1'b0, lo} + 9'h1;
      case (m)
         // Upper three low bits are left alone, software masks them
         mode_13bit: res = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
         mode_16bit: res = c16;
         mode_reload: res = {c8[8], hi, c8[8] ? hi : c8[7:0]};
         default: res = {1'b0, hi, lo};
      endcase
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   assign wr_ctrl = sfr_wr && (sfr_addr == `TCTRL_ADDR);
   assign wr_mode = sfr_wr && (sfr_addr == `TMODE_ADDR);
   assign wr_low0 = sfr_wr && (sfr_addr == `T0LOW_ADDR);
   assign wr_high0 = sfr_wr && (sfr_addr == `T0HIGH_ADDR);
   assign wr_low1 = sfr_wr && (sfr_addr == `T1LOW_ADDR);
   assign wr_high1 = sfr_wr && (sfr_addr == `T1HIGH_ADDR);
   assign bit_hit = sfr_bit_wr && (sfr_bit_addr[7:3] == `TCTRL_BIT_PAGE);

   ////////////////////////////////////////////////////////////////////////
   // Count enables
   always_comb begin
      mode0 = timer_mode_type'(timer_mode_register_reg[`MODE0_HI:`MODE0_LO]);
      mode1 = timer_mode_type'(timer_mode_register_reg[`MODE1_HI:`MODE1_LO]);
      split = (mode0 == mode_split);
      timer0_gate_bit_ok = ~timer_mode_register_reg[`GATE_ZERO_BIT] | (g0_level == ext_zero_polarity);
      timer1_gate_bit_ok = ~timer_mode_register_reg[`GATE_ONE_BIT] | (g1_level == ext_one_polarity);
      inc0 = timer_control_reg[`RUN0_BIT] & timer0_gate_bit_ok
         & (timer_mode_register_reg[`CSEL0_BIT] ? c0_fall : timer0_tick);
      // Split high half: clock only, enabled by timer 1 run
      inc0_high = split & timer_control_reg[`RUN1_BIT] & timer0_tick;
      if (split) begin
         inc1 = (mode1 != mode_split) & timer1_tick;
      end else begin
         inc1 = timer_control_reg[`RUN1_BIT] & timer1_gate_bit_ok & (mode1 != mode_split)
            & (timer_mode_register_reg[`CSEL1_BIT] ? c1_fall : timer1_tick);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter steps
   always_comb begin
      step0 = count_step(split ? mode_reload : mode0, timer0_low_byte_reg,
                         timer0_high_byte_reg);
      if (split) begin
         // Split low half is a free 8-bit wrap, no reload
         step0 = {step0[16], timer0_high_byte_reg,
                  timer0_low_byte_reg + `COUNT_ONE};
      end
      step0_high = {1'b0, timer0_high_byte_reg} + 9'h1;
      step1 = count_step(mode1, timer1_low_byte_reg, timer1_high_byte_reg);
      ovf0 = inc0 & step0[16];
      ovf0_high = inc0_high & step0_high[8];
      ovf1_evt = inc1 & step1[16];
   end

   ////////////////////////////////////////////////////////////////////////
   // External interrupt detect per type and polarity
   always_comb begin
      act0 = (g0_level == ext_zero_polarity);
      act1 = (g1_level == ext_one_polarity);
      edge0 = ext_zero_polarity ? g0_rise : g0_fall;
      edge1 = ext_one_polarity ? g1_rise : g1_fall;
   end

   ////////////////////////////////////////////////////////////////////////
   // Register next values; hardware sets win over clears
   always_comb begin
      timer_mode_register_next = wr_mode ? sfr_wdata : timer_mode_register_reg;
      timer_control_next = wr_ctrl ? sfr_wdata : timer_control_reg;
      if (bit_hit) begin
         timer_control_next[sfr_bit_addr[2:0]] = sfr_bit_value;
      end
      if (vector_timer0) begin
         timer_control_next[`OVF0_BIT] = 1'b0;
      end
      if (vector_timer1) begin
         timer_control_next[`OVF1_BIT] = 1'b0;
      end
      if (vector_ext_zero && timer_control_reg[`XTYPE0_BIT]) begin
         timer_control_next[`XFLAG0_BIT] = 1'b0;
      end
      if (vector_ext_one && timer_control_reg[`XTYPE1_BIT]) begin
         timer_control_next[`XFLAG1_BIT] = 1'b0;
      end
      if (ovf0) begin
         timer_control_next[`OVF0_BIT] = 1'b1;
      end
      if (ovf0_high || (ovf1_evt && !split)) begin
         timer_control_next[`OVF1_BIT] = 1'b1;
      end
      if (timer_control_reg[`XTYPE0_BIT] ? edge0 : act0) begin
         timer_control_next[`XFLAG0_BIT] = 1'b1;
      end
      if (timer_control_reg[`XTYPE1_BIT] ? edge1 : act1) begin
         timer_control_next[`XFLAG1_BIT] = 1'b1;
      end
      // Software byte writes take priority over counting
      timer0_low_byte_next = wr_low0 ? sfr_wdata : (inc0 ? step0[7:0] : timer0_low_byte_reg);
      if (wr_high0) begin
         timer0_high_byte_next = sfr_wdata;
      end else if (split) begin
         timer0_high_byte_next = inc0_high ? step0_high[7:0] : timer0_high_byte_reg;
      end else begin
         timer0_high_byte_next = inc0 ? step0[15:8] : timer0_high_byte_reg;
      end
      timer1_low_byte_next = wr_low1 ? sfr_wdata : (inc1 ? step1[7:0] : timer1_low_byte_reg);
      timer1_high_byte_next = wr_high1 ? sfr_wdata : (inc1 ? step1[15:8] : timer1_high_byte_reg);
      irq0_next = timer_control_next[`OVF0_BIT] & timer0_irq_enable;
      irq1_next = timer_control_next[`OVF1_BIT] & timer1_irq_enable;
      ovf1_next = ovf1_evt;
      case (sfr_addr)
         `TCTRL_ADDR: rdata_next = timer_control_reg;
         `TMODE_ADDR: rdata_next = timer_mode_register_reg;
         `T0LOW_ADDR: rdata_next = timer0_low_byte_reg;
         `T1LOW_ADDR: rdata_next = timer1_low_byte_reg;
         `T0HIGH_ADDR: rdata_next = timer0_high_byte_reg;
         `T1HIGH_ADDR: rdata_next = timer1_high_byte_reg;
         default: rdata_next = `BYTE_RESET;
      endcase
      if (!sfr_rd) begin
         rdata_next = rdata_reg;
      end
   end

   // State registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         timer_control_reg <= `BYTE_RESET;
         timer_mode_register_reg <= `BYTE_RESET;
         timer0_low_byte_reg <= `BYTE_RESET;
         timer0_high_byte_reg <= `BYTE_RESET;
         timer1_low_byte_reg <= `BYTE_RESET;
         timer1_high_byte_reg <= `BYTE_RESET;
         rdata_reg <= `BYTE_RESET;
         irq0_reg <= 1'b0;
         irq1_reg <= 1'b0;
         ovf1_reg <= 1'b0;
      end else begin
         timer_control_reg <= timer_control_next;
         timer_mode_register_reg <= timer_mode_register_next;
         timer0_low_byte_reg <= timer0_low_byte_next;
         timer0_high_byte_reg <= timer0_high_byte_next;
         timer1_low_byte_reg <= timer1_low_byte_next;
         timer1_high_byte_reg <= timer1_high_byte_next;
         rdata_reg <= rdata_next;
         irq0_reg <= irq0_next;
         irq1_reg <= irq1_next;
         ovf1_reg <= ovf1_next;
      end
   end

   assign sfr_rdata = rdata_reg;
   assign timer0_irq = irq0_reg;
   assign timer1_irq = irq1_reg;
   assign timer1_overflow = ovf1_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking dc @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_mode1_step;
      (!split && mode0 == mode_16bit && inc0 && !wr_low0 && !wr_high0) |=>
         ({timer0_high_byte_reg, timer0_low_byte_reg} ==
          16'($past({timer0_high_byte_reg, timer0_low_byte_reg}) + 16'h1));
   endproperty
   a_mode1_step: assert property (p_mode1_step) else $error("mode 1 step wrong");

   property p_reload;
      (!split && mode0 == mode_reload && inc0 && timer0_low_byte_reg == `BYTE_ONES
       && !wr_low0 && !wr_high0) |=>
         (timer0_low_byte_reg == $past(timer0_high_byte_reg)
          && timer_control_reg[`OVF0_BIT]);
   endproperty
   a_reload: assert property (p_reload) else $error("reload or flag missing");

   property p_high_kept;
      (!split && mode0 == mode_reload && !wr_high0) |=> $stable(timer0_high_byte_reg);
   endproperty
   a_high_kept: assert property (p_high_kept) else $error("reload value changed");

   property p_stopped;
      (!timer_control_reg[`RUN0_BIT] && !wr_low0 && !wr_high0 && !split) |=>
         $stable(timer0_low_byte_reg) && $stable(timer0_high_byte_reg);
   endproperty
   a_stopped: assert property (p_stopped) else $error("timer 0 ran while off");

   property p_split_flag;
      (split && timer_control_reg[`RUN1_BIT] && timer0_tick
       && timer0_high_byte_reg == `BYTE_ONES && !wr_high0) |=>
         timer_control_reg[`OVF1_BIT] ##1 (timer1_irq || !timer1_irq_enable);
   endproperty
   a_split_flag: assert property (p_split_flag) else $error("split overflow lost");

   property p_t1_halt;
      (split && mode1 == mode_split && !wr_low1 && !wr_high1) |=>
         $stable(timer1_low_byte_reg) && $stable(timer1_high_byte_reg) && !timer1_overflow;
   endproperty
   a_t1_halt: assert property (p_t1_halt) else $error("timer 1 ran in mode 3");

   property p_irq;
      // Request follows the stored flag and the enable of the cycle before
      (timer_control_reg[`OVF0_BIT] && $past(timer0_irq_enable)) |-> timer0_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("timer 0 request missing");

   property p_vector_clear;
      (vector_timer0 && !ovf0 && !wr_ctrl && !bit_hit) |=> !timer_control_reg[`OVF0_BIT];
   endproperty
   a_vector_clear: assert property (p_vector_clear) else $error("flag kept on vector");

   property p_level_flag;
      (!timer_control_reg[`XTYPE0_BIT] && act0) |=> timer_control_reg[`XFLAG0_BIT];
   endproperty
   a_level_flag: assert property (p_level_flag) else $error("level irq not flagged");

   c_reload: cover property (!split && mode0 == mode_reload && ovf0);
   c_split: cover property (ovf0_high);
   c_edge: cover property (timer_control_reg[`XTYPE0_BIT] && edge0);
   c_baud: cover property (split && timer1_overflow);
endmodule
`default_nettype wire

// File: dv/pin_event_source.sv
`timescale 1ns/1ps
`default_nettype none
module pin_event_source (
   // Clock
   input wire logic clk,
   // One pulse asks for one falling edge on that pin
   input wire logic [1:0] fall_req,
   // Count pins, idle high
   output logic count_pin_zero,
   output logic count_pin_one,
   output logic busy
);
   logic [2:0] hold_reg [2] = '{3'h0, 3'h0};
   // Low three cycles, then high three, so each level is seen three times
   always @(posedge clk) begin
      for (int i = 0; i < 2; i++) begin
         if (hold_reg[i] != 3'h0)
            hold_reg[i] <= hold_reg[i] - 3'h1;
         else if (fall_req[i])
            hold_reg[i] <= 3'h6;
      end
   end
   // Pins stay high between events, no stray edges
   assign count_pin_zero = hold_reg[0] < 3'h4;
   assign count_pin_one = hold_reg[1] < 3'h4;
   assign busy = (hold_reg[0] != 3'h0) || (hold_reg[1] != 3'h0);
endmodule
`default_nettype wire

// File: dv/dual_timer_tb.sv
`include "timer_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module dual_timer_tb
   import timer_pkg::*;
;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_bit_addr = 8'h00, sfr_rdata;
   logic sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_bit_value = 1'b0, sfr_bit_wr = 1'b0;
   // Gate pins idle high and active low, matching the sampler reset level
   logic [1:0] tick = 2'b00, gate_in = 2'b11, pol = 2'b00, irq_en = 2'b11;
   logic [1:0] vec_t = 2'b00, vec_ext = 2'b00, fall_req = 2'b00, irq;
   logic pin0, pin1, pins_busy, t1_ovf;
   int n_fail = 0, total_checks = 0, cycles = 0, n_ovf = 0;

   dual_timer u_dual_timer (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
      .sfr_bit_addr(sfr_bit_addr), .sfr_bit_value(sfr_bit_value), .sfr_bit_wr(sfr_bit_wr),
      .timer0_tick(tick[0]), .timer1_tick(tick[1]), .count_pin_zero(pin0),
      .count_pin_one(pin1), .ext_gate_zero_input(gate_in[0]),
      .ext_gate_one_input(gate_in[1]), .ext_zero_polarity(pol[0]), .ext_one_polarity(pol[1]),
      .timer0_irq_enable(irq_en[0]), .timer1_irq_enable(irq_en[1]),
      .vector_timer0(vec_t[0]), .vector_timer1(vec_t[1]), .vector_ext_zero(vec_ext[0]),
      .vector_ext_one(vec_ext[1]), .timer0_irq(irq[0]), .timer1_irq(irq[1]),
      .timer1_overflow(t1_ovf));
   pin_event_source u_pin_event_source (.clk(clk), .fall_req(fall_req),
      .count_pin_zero(pin0), .count_pin_one(pin1), .busy(pins_busy));

   ////////////////////////////////////////////////////////////////////////////
   // Clock, hang guard and overflow pulse counter
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (t1_ovf === 1'b1)
         n_ovf <= n_ovf + 1;
      if (cycles == 20000) begin
         n_fail++;
         finish_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("checks=%0d fails=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Bus cycles: strobe launched on one edge, taken on the next
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_wr <= 1'b1;
      sfr_addr <= a;
      sfr_wdata <= d;
      @(posedge clk);
      sfr_wr <= 1'b0;
   endtask
   task automatic bw(input logic [7:0] a, input logic v);
      @(posedge clk);
      sfr_bit_wr <= 1'b1;
      sfr_bit_addr <= a;
      sfr_bit_value <= v;
      @(posedge clk);
      sfr_bit_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      sfr_rd <= 1'b1;
      sfr_addr <= a;
      @(posedge clk);
      sfr_rd <= 1'b0;
      // Data lands at the taking edge and is read one edge later
      @(posedge clk);
      check(sfr_rdata, exp);
   endtask
   task automatic set_line(input int which, input int i, input logic v);
      case (which)
         0: tick[i] <= v;
         1: vec_t[i] <= v;
         2: vec_ext[i] <= v;
         default: fall_req[i] <= v;
      endcase
   endtask
   // One-cycle pulses on ticks, vectors or pin requests
   task automatic pulse(input int which, input int i, input int n);
      repeat (n) begin
         @(posedge clk);
         set_line(which, i, 1'b1);
         @(posedge clk);
         set_line(which, i, 1'b0);
      end
   endtask
   task automatic fall(input int i);
      pulse(3, i, 1);
      @(posedge clk);
      for (int k = 0; k < 16 && pins_busy === 1'b1; k++)
         @(posedge clk);
      repeat (2) @(posedge clk);
   endtask
   // Synchroniser latency of the pin path
   task automatic settle();
      repeat (5) @(posedge clk);
   endtask
   function automatic logic [7:0] mw(input timer_mode_type m, input int t, input logic [1:0] gc);
      return {4'h0, gc, m} << (4 * t);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] lo, hi, run, tf, ie;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      for (int a = 8'h88; a < 8'h8e; a++)
         rd(a[7:0], 8'h00);
      wr(8'h90, 8'hff);
      bw(8'h90, 1'b1);
      rd(8'h90, 8'h00);
      rd(`TCTRL_ADDR, 8'h00);
      bw(8'h8c, 1'b1);
      rd(`TCTRL_ADDR, 8'h10);
      $display("test reset and bus done");
      for (int t = 0; t < 2; t++) begin
         lo = 8'h8a + t;
         hi = 8'h8c + t;
         run = 8'h10 << (2 * t);
         tf = 8'h20 << (2 * t);
         wr(`TMODE_ADDR, mw(mode_16bit, t, 2'b00));
         wr(lo, 8'hff);
         wr(hi, 8'hfe);
         wr(`TCTRL_ADDR, run);
         pulse(0, t, 1);
         rd(hi, 8'hff);
         rd(`TCTRL_ADDR, run);
         wr(lo, 8'hff);
         pulse(0, t, 1);
         rd(hi, 8'h00);
         rd(`TCTRL_ADDR, run | tf);
         check({7'h00, irq[t]}, 8'h01);
         pulse(1, t, 1);
         rd(`TCTRL_ADDR, run);
         check({7'h00, irq[t]}, 8'h00);
         wr(`TMODE_ADDR, mw(mode_reload, t, 2'b00));
         wr(hi, 8'h80);
         wr(lo, 8'hff);
         pulse(0, t, 1);
         rd(lo, 8'h80);
         rd(hi, 8'h80);
         rd(`TCTRL_ADDR, run | tf);
         pulse(0, t, 1);
         rd(lo, 8'h81);
         wr(`TMODE_ADDR, mw(mode_13bit, t, 2'b00));
         wr(`TCTRL_ADDR, run);
         wr(hi, 8'hff);
         wr(lo, 8'hff);
         pulse(0, t, 1);
         rd(lo, 8'he0);
         rd(hi, 8'h00);
         rd(`TCTRL_ADDR, run | tf);
         wr(`TMODE_ADDR, mw(mode_16bit, t, 2'b10));
         wr(`TCTRL_ADDR, run);
         wr(lo, 8'h00);
         pulse(0, t, 2);
         rd(lo, 8'h00);
         gate_in[t] <= 1'b0;
         settle();
         pulse(0, t, 2);
         rd(lo, 8'h02);
         gate_in[t] <= 1'b1;
         settle();
         wr(`TCTRL_ADDR, 8'h00);
         pulse(0, t, 1);
         rd(lo, 8'h02);
         wr(`TMODE_ADDR, mw(mode_16bit, t, 2'b01));
         wr(lo, 8'h00);
         wr(`TCTRL_ADDR, run);
         repeat (3) fall(t);
         pulse(0, t, 2);
         rd(lo, 8'h03);
         wr(`TCTRL_ADDR, 8'h00);
         $display("test timer %0d modes done", t);
      end
      for (int i = 0; i < 2; i++) begin
         ie = 8'h02 << (2 * i);
         gate_in[i] <= 1'b0;
         settle();
         rd(`TCTRL_ADDR, ie);
         bw(8'h89 + 2 * i, 1'b0);
         rd(`TCTRL_ADDR, ie);
         gate_in[i] <= 1'b1;
         settle();
         bw(8'h89 + 2 * i, 1'b0);
         rd(`TCTRL_ADDR, 8'h00);
         bw(8'h88 + 2 * i, 1'b1);
         gate_in[i] <= 1'b0;
         settle();
         rd(`TCTRL_ADDR, ie | (ie >> 1));
         pulse(2, i, 1);
         rd(`TCTRL_ADDR, ie >> 1);
         // Active high: only a rising pin edge may flag
         pol[i] <= 1'b1;
         gate_in[i] <= 1'b1;
         settle();
         rd(`TCTRL_ADDR, ie | (ie >> 1));
         pol[i] <= 1'b0;
         wr(`TCTRL_ADDR, 8'h00);
         $display("test external flag %0d done", i);
      end
      settle();
      wr(`TMODE_ADDR, 8'h13);
      wr(8'h8a, 8'hff);
      wr(8'h8c, 8'hff);
      wr(8'h8b, 8'hff);
      wr(8'h8d, 8'hff);
      wr(`TCTRL_ADDR, 8'h50);
      pulse(0, 0, 1);
      rd(8'h8a, 8'h00);
      rd(8'h8c, 8'h00);
      rd(`TCTRL_ADDR, 8'hf0);
      wr(`TCTRL_ADDR, 8'h50);
      // Timer 1 wrapped three times in the mode tests before
      check(n_ovf[7:0], 8'h03);
      pulse(0, 1, 1);
      rd(8'h8b, 8'h00);
      rd(`TCTRL_ADDR, 8'h50);
      check(n_ovf[7:0], 8'h04);
      wr(`TCTRL_ADDR, 8'h10);
      pulse(0, 0, 1);
      rd(8'h8c, 8'h00);
      rd(8'h8a, 8'h01);
      pulse(0, 1, 1);
      rd(8'h8b, 8'h01);
      wr(`TMODE_ADDR, 8'h53);
      fall(1);
      rd(8'h8b, 8'h01);
      wr(`TMODE_ADDR, 8'h33);
      pulse(0, 1, 1);
      rd(8'h8b, 8'h01);
      $display("test split mode done");
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd(`TCTRL_ADDR, 8'h00);
      rd(`TMODE_ADDR, 8'h00);
      $display("test second reset done");
      finish_test();
   end
endmodule
`default_nettype wire
